/* File: mdac_serial_command_decoder.v */
// Serial command decoder of a 12-bit multiplying converter, with APB access.
// Assumes frame select, serial clock and data come from pins outside mclk.
//
// Functional notes
// - Serial bits are captured on falling clock edges after reset.
// - Reset leaves daisy-chain mode on; commands run at frame select rise.
// - Reset loads zero scale into the converter register.
// - Command 0000 does nothing to code or modes.
// - Command 0010 loads the code for shifting out on serial data out.
// - Command 1001 leaves daisy-chain; commands then run at 16th edge.
// - Command 1010 makes rising clock edges the capture edge.
// - Command 1011 forces the code to zero scale.
// - Command 1100 forces the code to midscale.
// - Frames shift in MSB first, command bits before data bits.
// - A frame is 16 bits: command in 15..12, code in 11..0.
// - Execute at frame select rise in chain mode, else at 16th edge.
// - Only command 0001 moves the twelve data bits into the code.
// - Early frame select rise in stand-alone clears shifter, changes nothing.
`timescale 1ns/10ps
`default_nettype none
`include "mdac_map.vh"

module mdac_serial_command_decoder #(
  parameter FRAME_BITS = `FRAME_BITS,
  parameter CNT_W = 5
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Serial pins, frame select active low
  input wire frame_sel_n,
  input wire serial_clk,
  input wire serial_data_in,
  output wire serial_data_out,
  // Converter side
  output wire [11:0] converter_code,
  output wire exec_strobe
);

  localparam ST_IDLE = 3'b001;
  localparam ST_SHIFT = 3'b010;
  localparam ST_DONE = 3'b100;
  // Counts are worked out at full width, then cut to the counter width
  localparam [31:0] LAST_EDGE_FULL = FRAME_BITS - 1;
  localparam [31:0] FRAME_BITS_FULL = FRAME_BITS;
  localparam [CNT_W-1:0] LAST_EDGE = LAST_EDGE_FULL[CNT_W-1:0];
  localparam [CNT_W-1:0] FULL_CNT = FRAME_BITS_FULL[CNT_W-1:0];

  function [3:0] frame_cmd;
    input [15:0] word;
    begin
      frame_cmd = word[`CMD_MSB:`CMD_LSB];
    end
  endfunction

  function [11:0] frame_data;
    input [15:0] word;
    begin
      frame_data = word[`DATA_MSB:`DATA_LSB];
    end
  endfunction

  // Status word layout, kept in one place for the read mux
  function [31:0] status_word;
    input chain;
    input rise;
    input active;
    input [4:0] edges;
    input [3:0] last_cmd;
    begin
      status_word = 32'h00000000;
      status_word[`ST_CHAIN] = chain;
      status_word[`ST_RISE] = rise;
      status_word[`ST_ACTIVE] = active;
      status_word[`ST_CNT_MSB:`ST_CNT_LSB] = edges;
      status_word[`ST_CMD_MSB:`ST_CMD_LSB] = last_cmd;
    end
  endfunction

  // Synchronised pins: frame select idles high
  wire [2:0] pins_s;
  wire frame_n_s;
  wire sclk_s;
  wire din_s;

  pin_sync #(
    .WIDTH(3),
    .RESET_VAL(3'h4)
  ) u_pin_sync (
    .mclk(mclk),
    .rst(rst),
    .pin_in({frame_sel_n, serial_clk, serial_data_in}),
    .pin_out(pins_s)
  );

  assign frame_n_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign din_s = pins_s[0];

  reg sclk_q_ff;
  reg frame_q_ff;
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [CNT_W-1:0] cnt_ff;
  reg [CNT_W-1:0] nxt_cnt;
  reg chain_ff;
  reg rise_edge_ff;
  reg [11:0] code_ff;
  reg sdo_ff;
  reg strobe_ff;
  reg [3:0] last_cmd_ff;
  reg [15:0] exec_cnt_ff;
  reg link_en_ff;
  reg [31:0] prdata_ff;
  reg pready_ff;
  reg pslverr_ff;

  wire [15:0] shreg;
  reg shift_en;
  reg shift_clr;
  reg exec;
  reg [15:0] exec_word;
  reg [31:0] nxt_rdata;

  // Edge detection on the second synchroniser stage only
  wire sclk_rise = sclk_s & ~sclk_q_ff;
  wire sclk_fall = ~sclk_s & sclk_q_ff;
  // default falling capture; rising after command
  wire active_edge = rise_edge_ff ? sclk_rise : sclk_fall;
  wire inactive_edge = rise_edge_ff ? sclk_fall : sclk_rise;
  wire frame_rise = frame_n_s & ~frame_q_ff;
  wire frame_fall = ~frame_n_s & frame_q_ff;
  wire [15:0] shifted = {shreg[14:0], din_s};

  wire [3:0] cmd = frame_cmd(exec_word);
  // readback reloads the shifter so the next frame carries the code out
  wire readback = exec && (cmd == `CMD_READBACK);

  // APB decode
  wire apb_access = psel & penable & ~pready_ff;
  wire apb_write = apb_access & pwrite;
  wire hit_config = (paddr == `OFS_CONFIG);
  wire hit_status = (paddr == `OFS_STATUS);
  wire hit_code = (paddr == `OFS_CODE);
  wire hit_count = (paddr == `OFS_EXEC_COUNT);
  wire addr_ok = hit_config | hit_status | hit_code | hit_count;
  wire restore = apb_write & hit_config & pwdata[`CFG_RESTORE];

  frame_shifter #(
    .WIDTH(16)
  ) u_frame_shifter (
    .mclk(mclk),
    .rst(rst),
    .shift_en(shift_en),
    .bit_in(din_s),
    .clear(shift_clr),
    .load_en(readback),
    .load_val({`CMD_NOP, code_ff}),
    .value(shreg)
  );

  // Frame sequencing
  always @* begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    shift_en = 1'b0;
    shift_clr = 1'b0;
    exec = 1'b0;
    exec_word = shreg;
    case (state_ff)
      ST_IDLE: begin
        if (frame_fall && link_en_ff) begin
          nxt_state = ST_SHIFT;
          nxt_cnt = {CNT_W{1'b0}};
        end
      end
      ST_SHIFT: begin
        if (!link_en_ff) begin
          nxt_state = ST_IDLE;
          shift_clr = 1'b1;
        end else if (frame_rise) begin
          nxt_state = ST_IDLE;
          // chain mode executes at frame select rise
          if (chain_ff && cnt_ff >= FULL_CNT) begin
            exec = 1'b1;
          end else begin
            shift_clr = 1'b1;
          end
        end else if (active_edge) begin
          shift_en = 1'b1;
          if (cnt_ff != {CNT_W{1'b1}}) begin
            nxt_cnt = cnt_ff + 1'b1;
          end
          // stand-alone executes on the 16th active edge
          if (!chain_ff && cnt_ff == LAST_EDGE) begin
            exec = 1'b1;
            exec_word = shifted;
            nxt_state = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        if (frame_rise || !link_en_ff) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (rst) begin
      sclk_q_ff <= 1'b0;
      frame_q_ff <= 1'b1;
      state_ff <= ST_IDLE;
      cnt_ff <= {CNT_W{1'b0}};
    end else begin
      sclk_q_ff <= sclk_s;
      frame_q_ff <= frame_n_s;
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  // Command execution and mode state
  always @(posedge mclk) begin
    if (rst || restore) begin
      rise_edge_ff <= 1'b0;
      chain_ff <= 1'b1;
      code_ff <= `CODE_ZERO;
      strobe_ff <= 1'b0;
      last_cmd_ff <= `CMD_NOP;
    end else begin
      strobe_ff <= exec;
      if (exec) begin
        last_cmd_ff <= cmd;
        case (cmd)
          // only load moves the data bits
          `CMD_LOAD: begin
            code_ff <= frame_data(exec_word);
          end
          `CMD_CHAIN_OFF: begin
            chain_ff <= 1'b0;
          end
          `CMD_RISE_EDGE: begin
            rise_edge_ff <= 1'b1;
          end
          `CMD_CLR_ZERO: begin
            code_ff <= `CODE_ZERO;
          end
          `CMD_CLR_MID: begin
            code_ff <= `CODE_MID;
          end
          default: begin
            code_ff <= code_ff;
          end
        endcase
      end
    end
  end

  // Serial out changes on the inactive edge so the next device samples it
  always @(posedge mclk) begin
    if (rst) begin
      sdo_ff <= 1'b0;
    end else if (readback) begin
      sdo_ff <= 1'b0;
    end else if (state_ff != ST_IDLE && inactive_edge) begin
      sdo_ff <= shreg[15];
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      exec_cnt_ff <= 16'h0000;
    end else if (exec) begin
      exec_cnt_ff <= exec_cnt_ff + 16'h0001;
    end
  end

  // Read mux: zero outside a read so prdata idles at zero between answers
  always @* begin
    nxt_rdata = 32'h00000000;
    if (apb_access && !pwrite) begin
      if (hit_config) begin
        nxt_rdata[`CFG_LINK_EN] = link_en_ff;
      end
      if (hit_status) begin
        nxt_rdata = status_word(chain_ff, rise_edge_ff, ~state_ff[0], cnt_ff, last_cmd_ff);
      end
      if (hit_code) begin
        nxt_rdata[11:0] = code_ff;
      end
      if (hit_count) begin
        nxt_rdata[15:0] = exec_cnt_ff;
      end
    end
  end

  // APB slave: answers in the second access cycle
  always @(posedge mclk) begin
    if (rst) begin
      link_en_ff <= 1'b1;
      prdata_ff <= 32'h00000000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= apb_access;
      pslverr_ff <= apb_access & ~addr_ok;
      prdata_ff <= nxt_rdata;
      if (apb_write && hit_config) begin
        link_en_ff <= pwdata[`CFG_LINK_EN];
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign serial_data_out = sdo_ff;
  assign converter_code = code_ff;
  assign exec_strobe = strobe_ff;

endmodule // mdac_serial_command_decoder

`default_nettype wire

/* File: mdac_map.vh */
// Constants for the serial command decoder: frame layout, commands,
// register offsets, field positions and reset values.
// Assumes it is included by bare name from the design files.
`ifndef MDAC_MAP_VH
`define MDAC_MAP_VH

// Frame layout
`define FRAME_BITS 16
`define CMD_MSB 15
`define CMD_LSB 12
`define DATA_MSB 11
`define DATA_LSB 0

// Command codes
`define CMD_NOP 4'h0
`define CMD_LOAD 4'h1
`define CMD_READBACK 4'h2
`define CMD_CHAIN_OFF 4'h9
`define CMD_RISE_EDGE 4'hA
`define CMD_CLR_ZERO 4'hB
`define CMD_CLR_MID 4'hC

// Converter codes
`define CODE_ZERO 12'h000
`define CODE_MID 12'h800

// Register byte offsets
`define OFS_CONFIG 12'h000
`define OFS_STATUS 12'h004
`define OFS_CODE 12'h008
`define OFS_EXEC_COUNT 12'h00C

// Config fields
`define CFG_LINK_EN 0
`define CFG_RESTORE 1
`define CFG_RESET 2'h1

// Status fields
`define ST_CHAIN 0
`define ST_RISE 1
`define ST_ACTIVE 2
`define ST_CNT_LSB 4
`define ST_CNT_MSB 8
`define ST_CMD_LSB 12
`define ST_CMD_MSB 15

`endif

/* File: pin_sync.v */
// Two-stage synchroniser for a group of pins from outside the mclk domain.
// Assumes the pins are plain levels; only the second stage is read outside.
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
  parameter WIDTH = 3,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Pins in, synchronised levels out
  input wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] pin_out
);

  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] stable_ff;

  always @(posedge mclk) begin
    if (rst) begin
      meta_ff <= RESET_VAL;
      stable_ff <= RESET_VAL;
    end else begin
      meta_ff <= pin_in;
      stable_ff <= meta_ff;
    end
  end

  assign pin_out = stable_ff;

endmodule // pin_sync

`default_nettype wire

/* File: frame_shifter.v */
// Input shift register of the serial frame, MSB first.
// Load takes priority over clear and clear over shift inside the shifter itself.
`timescale 1ns/10ps
`default_nettype none

module frame_shifter #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Control
  input wire shift_en,
  input wire bit_in,
  input wire clear,
  input wire load_en,
  input wire [WIDTH-1:0] load_val,
  // Contents
  output wire [WIDTH-1:0] value
);

  reg [WIDTH-1:0] shreg_ff;

  always @(posedge mclk) begin
    if (rst) begin
      shreg_ff <= {WIDTH{1'b0}};
    end else if (load_en) begin
      shreg_ff <= load_val;
    end else if (clear) begin
      shreg_ff <= {WIDTH{1'b0}};
    end else if (shift_en) begin
      shreg_ff <= {shreg_ff[WIDTH-2:0], bit_in};
    end
  end

  assign value = shreg_ff;

endmodule // frame_shifter

`default_nettype wire

/* File: mdac_asserts.sv */
// Port checks of the serial command decoder: APB answer, strobe, code.
// Assumes it is bound to the decoder top and sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module mdac_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Serial and converter
  input wire logic frame_sel_n,
  input wire logic [11:0] converter_code,
  input wire logic exec_strobe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence taken_s;
    psel && penable && !pready;
  endsequence
  // Long enough for chain execution after frame select rises
  sequence quiet_s;
    frame_sel_n [*8] ##1 frame_sel_n [*4];
  endsequence
  a_apb_answer: assert property (taken_s |=> pready)
    else $error("access not answered");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("ready without access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h00000000)
    else $error("read data outside answer");
  a_strobe_pulse: assert property (exec_strobe |=> !exec_strobe)
    else $error("strobe longer than one cycle");
  a_code_cause: assert property (
    $changed(converter_code) && !$past(psel && pwrite) |-> exec_strobe)
    else $error("code changed without command");
  a_idle_quiet: assert property (quiet_s |-> !exec_strobe)
    else $error("command ran with no frame");
endmodule // mdac_asserts
bind mdac_serial_command_decoder mdac_asserts mdac_asserts_i (.mclk(mclk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .frame_sel_n(frame_sel_n), .converter_code(converter_code),
  .exec_strobe(exec_strobe));
`default_nettype wire

/* File: host_model.sv */
// Host serial controller: drives frame select, clock and data in.
// Assumes the decoder samples these pins with its own clock.
`timescale 1ns/10ps
`default_nettype none
module host_model (
  // Serial pins
  output logic frame_sel_n,
  output logic serial_clk,
  output logic serial_data_in,
  input wire logic serial_data_out
);
  initial begin
    frame_sel_n = 1'b1;
    serial_clk = 1'b1;
    serial_data_in = 1'b0;
  end
  // Clock stands at its inactive level outside frames; data is inverted
  // once its hold ends, so a wrong capture edge takes wrong bits.
  task automatic frame(input logic [15:0] w, input bit rise, input int n,
    output logic [15:0] rd);
    rd = 16'h0000;
    serial_clk = ~rise;
    #16 frame_sel_n = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      #16 serial_data_in = w[i];
      // out bit stands from the previous inactive edge
      #16 rd[i] = serial_data_out;
      serial_clk = rise;
      #16 serial_data_in = ~w[i];
      #16 serial_clk = ~rise;
    end
    #32;
    frame_sel_n = 1'b1;
    #64;
  endtask
endmodule // host_model
`default_nettype wire

/* File: mdac_serial_command_decoder_tb.sv */
// Bench of the serial command decoder: APB reads and serial frames.
// Assumes host_model drives the serial pins; mclk runs at 200 MHz.
`timescale 1ns/10ps
`default_nettype none
`include "mdac_map.vh"
module mdac_serial_command_decoder_tb;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, err, rise, chain;
  logic frame_sel_n, serial_clk, serial_data_in, serial_data_out, exec_strobe;
  logic [11:0] paddr, converter_code, code;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] word;
  int fail_count, total_checks, strobes, early;
  mdac_serial_command_decoder mdac_serial_command_decoder_i (.mclk(mclk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .frame_sel_n(frame_sel_n),
    .serial_clk(serial_clk), .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out), .converter_code(converter_code),
    .exec_strobe(exec_strobe));
  host_model host_model_i (.frame_sel_n(frame_sel_n), .serial_clk(serial_clk),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // A strobe while frame select is low means execution at the 16th edge
  always @(posedge mclk) begin
    if (exec_strobe === 1'b1) begin
      strobes++;
      if (frame_sel_n === 1'b0) early++;
    end
  end
  task check(input string what, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task fr(input logic [3:0] c, input logic [11:0] d, input int n, input int s);
    strobes = 0;
    early = 0;
    host_model_i.frame({c, d}, rise, n, word);
    #40;
    check("strobes", strobes, s);
    check("early", early, chain ? 0 : s);
    check("code", converter_code, code);
  endtask
  task t_reset;
    check("code", converter_code, 12'h000);
    apb(1'b0, `OFS_CONFIG, 32'h0);
    check("config", rd, 32'h00000001);
    apb(1'b0, `OFS_STATUS, 32'h0);
    check("status", rd & 32'hF00F, 32'h00000001);
    apb(1'b0, `OFS_EXEC_COUNT, 32'h0);
    check("count", rd, 32'h00000000);
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped err", err, 1'b1);
    check("unmapped data", rd, 32'h00000000);
    $display("reset test done");
  endtask
  task t_chain;
    code = 12'h5A3;
    fr(`CMD_LOAD, 12'h5A3, 16, 1);
    fr(`CMD_NOP, 12'hFFF, 16, 1);
    for (int c = 3; c < 16; c++) begin
      if (c < 9 || c > 12) fr(c[3:0], 12'hFFF, 16, 1);
    end
    apb(1'b0, `OFS_EXEC_COUNT, 32'h0);
    check("count", rd, 32'h0000000B);
    fr(`CMD_READBACK, 12'hABC, 16, 1);
    fr(`CMD_NOP, 12'h000, 16, 1);
    check("readback", word, {4'h0, code});
    $display("chain test done");
  endtask
  task t_clear;
    code = 12'h800;
    fr(`CMD_CLR_MID, 12'h123, 16, 1);
    code = 12'h000;
    fr(`CMD_CLR_ZERO, 12'h456, 16, 1);
    $display("clear test done");
  endtask
  task t_alone;
    fr(`CMD_CHAIN_OFF, 12'h000, 16, 1);
    chain = 1'b0;
    apb(1'b0, `OFS_STATUS, 32'h0);
    check("status", rd & 32'hF00F, 32'h00009000);
    fr(`CMD_LOAD, 12'h777, 10, 0);
    code = 12'h246;
    fr(`CMD_LOAD, 12'h246, 16, 1);
    $display("stand-alone test done");
  endtask
  task t_rise;
    fr(`CMD_RISE_EDGE, 12'h000, 16, 1);
    rise = 1'b1;
    code = 12'h3C7;
    fr(`CMD_LOAD, 12'h3C7, 16, 1);
    apb(1'b0, `OFS_STATUS, 32'h0);
    check("status", rd & 32'hF00F, 32'h00001002);
    $display("rising edge test done");
  endtask
  task t_config;
    apb(1'b1, `OFS_CONFIG, 32'h0);
    fr(`CMD_LOAD, 12'h111, 16, 0);
    apb(1'b1, `OFS_CONFIG, 32'h3);
    check("restored code", converter_code, 12'h000);
    chain = 1'b1;
    rise = 1'b0;
    apb(1'b0, `OFS_STATUS, 32'h0);
    check("status", rd & 32'hF00F, 32'h00000001);
    code = 12'h123;
    fr(`CMD_LOAD, 12'h123, 16, 1);
    $display("config test done");
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    rise = 1'b0;
    chain = 1'b1;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (8) @(posedge mclk);
    // chain-mode data frames come before the configuration frames
    t_reset;
    t_chain;
    t_clear;
    t_alone;
    t_rise;
    t_config;
    print_verdict;
  end
  initial begin
    #200000;
    fail_count++;
    print_verdict;
  end
endmodule // mdac_serial_command_decoder_tb
`default_nettype wire
